//--- inc/tcs_pkg.sv
// shared constants and carriers of the timer clear and count clock select block
package tcs_pkg;

   // counter and prescaler widths
   localparam int TCS_CNT_W = 16;
   localparam int TCS_PRE_W = 10;

   // prescale taps: divide by 4, 16, 64, 256 and 1024
   localparam int TCS_NUM_TAPS = 5;
   localparam int TCS_TAP_LOG2 [TCS_NUM_TAPS] = '{2, 4, 6, 8, 10};
   localparam int TCS_TAP_DIV4 = 0;
   localparam int TCS_TAP_DIV16 = 1;
   localparam int TCS_TAP_DIV64 = 2;
   localparam int TCS_TAP_DIV256 = 3;
   localparam int TCS_TAP_DIV1024 = 4;

   // clear select codes, bit 2 only exists on channels 0, 3 and 4
   localparam logic [2:0] TCS_CLR_OFF = 3'h0;
   localparam logic [2:0] TCS_CLR_A = 3'h1;
   localparam logic [2:0] TCS_CLR_B = 3'h2;
   localparam logic [2:0] TCS_CLR_SYNC = 3'h3;
   localparam logic [2:0] TCS_CLR_OFF_HI = 3'h4;
   localparam logic [2:0] TCS_CLR_C = 3'h5;
   localparam logic [2:0] TCS_CLR_D = 3'h6;
   localparam logic [2:0] TCS_CLR_SYNC_HI = 3'h7;
   localparam logic [1:0] TCS_CLR_SYNC_LOW = 2'h3;

   // reset value of the clear select readback
   localparam logic [2:0] TCS_SEL_RST = 3'h0;

   // edge select codes; bit 1 set means both edges
   localparam logic [1:0] TCS_EDGE_RISE = 2'h0;
   localparam logic [1:0] TCS_EDGE_FALL = 2'h1;
   localparam int TCS_EDGE_BOTH_BIT = 1;

   // channel groups as masks indexed by channel number
   localparam logic [4:0] TCS_FULL_CH_MASK = 5'h19;
   localparam logic [4:0] TCS_PHASE_CH_MASK = 5'h06;

   // count clock sources, one-hot
   typedef enum logic [10:0] {
      TCS_SRC_DIV1 = 11'h001,
      TCS_SRC_DIV4 = 11'h002,
      TCS_SRC_DIV16 = 11'h004,
      TCS_SRC_DIV64 = 11'h008,
      TCS_SRC_DIV256 = 11'h010,
      TCS_SRC_DIV1024 = 11'h020,
      TCS_SRC_EXT_A = 11'h040,
      TCS_SRC_EXT_B = 11'h080,
      TCS_SRC_EXT_C = 11'h100,
      TCS_SRC_EXT_D = 11'h200,
      TCS_SRC_OVF2 = 11'h400
   } tcs_src_type;

   // software selection fields of one channel
   typedef struct packed {
      logic [2:0] clear_sel;
      logic [1:0] edge_sel;
      logic [2:0] prescale_sel;
      logic buffer_a;
      logic buffer_b;
      logic phase_mode;
   } tcs_ctrl_type;

   // compare match or input capture pulses of general registers a to d
   typedef struct packed {
      logic match_a;
      logic match_b;
      logic match_c;
      logic match_d;
   } tcs_event_type;

endpackage

//--- rtl/tcs_prescaler.sv
// free running prescaler giving rise and fall enables for each divided clock
`timescale 1ns/1ns
module tcs_prescaler
   import tcs_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   output logic [TCS_NUM_TAPS-1:0] tap_rise,
   output logic [TCS_NUM_TAPS-1:0] tap_fall
);

   // whole state of the prescaler
   typedef struct packed {
      logic [TCS_PRE_W-1:0] count;
   } tcs_pre_state_type;

   tcs_pre_state_type st_r; // registered state
   tcs_pre_state_type st_nxt; // next state

   // the divider simply wraps; every tap is a power of two so no reload is needed
   always_comb begin
      st_nxt = st_r;
      st_nxt.count = TCS_PRE_W'(st_r.count + 1'b1);
   end

   // state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // a divided clock is high for the first half of its period, so its rising
   // edge falls on phase zero and its falling edge on the half period
   for (genvar i = 0; i < TCS_NUM_TAPS; i++) begin : g_tap
      localparam logic [TCS_PRE_W-1:0] MASK = TCS_PRE_W'((1 << TCS_TAP_LOG2[i]) - 1);
      localparam logic [TCS_PRE_W-1:0] HALF = TCS_PRE_W'(1 << (TCS_TAP_LOG2[i] - 1));
      assign tap_rise[i] = ((st_r.count & MASK) == '0);
      assign tap_fall[i] = ((st_r.count & MASK) == HALF);
   end

endmodule

//--- rtl/tcs_channel.sv
// one timer channel: clear source decode, count clock select and up/down counter, down only in phase counting
`timescale 1ns/1ns
module tcs_channel
   import tcs_pkg::*;
#(
   parameter int CHANNEL = 0, // channel number, 0 to 4
   parameter int CNT_W = TCS_CNT_W // counter width
)(
   input wire logic clk,
   input wire logic reset_n,
   input wire tcs_ctrl_type ctrl,
   input wire tcs_event_type gr_event,
   input wire logic timer_sync_enable,
   input wire logic sync_clear_in,
   input wire logic ext_count_clock_a,
   input wire logic ext_count_clock_b,
   input wire logic ext_count_clock_c,
   input wire logic ext_count_clock_d,
   input wire logic channel2_counter_wrap,
   input wire logic phase_step,
   input wire logic phase_down,
   output logic [CNT_W-1:0] timer_counter_value,
   output logic [2:0] clear_select_rd,
   output logic counter_cleared,
   output logic counter_wrap,
   output logic count_tick
);

   // whole state of the channel
   typedef struct packed {
      logic [CNT_W-1:0] counter; // timer counter value
      logic [3:0] pin_prev; // last sample of the external pins
      logic [2:0] sel_rd; // clear select as software reads it
      logic cleared; // counter was cleared at the last edge
      logic wrap; // counter wrapped at the last edge
      logic tick; // counter stepped at the last edge
   } tcs_chan_state_type;

   // channel features fixed by the channel number
   localparam logic HAS_CD = TCS_FULL_CH_MASK[CHANNEL];
   localparam logic HAS_PHASE = TCS_PHASE_CH_MASK[CHANNEL];

   tcs_chan_state_type st_r; // registered state
   tcs_chan_state_type st_nxt; // next state
   logic [TCS_NUM_TAPS-1:0] tap_rise; // divided clock rising edges
   logic [TCS_NUM_TAPS-1:0] tap_fall; // divided clock falling edges
   logic [3:0] pins; // external clock pins as one vector
   logic [3:0] pin_rise; // pin rising edges
   logic [3:0] pin_fall; // pin falling edges
   logic [2:0] eff_sel; // clear select after reserved bits
   tcs_src_type src; // decoded count clock source
   logic phase_on; // phase counting owns the counter
   logic clr; // clear the counter at this edge
   logic step; // advance the counter at this edge

   // divided-clock enables from this channel's own prescaler
   tcs_prescaler u_prescaler (
      .clk(clk),
      .reset_n(reset_n),
      .tap_rise(tap_rise),
      .tap_fall(tap_fall)
   );

   // pick the counting edge out of a rising and a falling event
   function automatic logic edge_pick(input logic [1:0] es, input logic rise, input logic fall);
      if (es[TCS_EDGE_BOTH_BIT]) begin
         edge_pick = rise | fall;
      end else if (es == TCS_EDGE_FALL) begin
         edge_pick = fall;
      end else begin
         edge_pick = rise;
      end
   endfunction

   // map the prescale code to a source; the table differs per channel
   function automatic tcs_src_type decode_src(input int ch, input logic [2:0] psc);
      tcs_src_type s;
      s = TCS_SRC_DIV1;
      unique case (psc)
         3'h0: begin
            s = TCS_SRC_DIV1;
         end
         3'h1: begin
            s = TCS_SRC_DIV4;
         end
         3'h2: begin
            s = TCS_SRC_DIV16;
         end
         3'h3: begin
            s = TCS_SRC_DIV64;
         end
         3'h4: begin
            // channels 3 and 4 have no pin here, they take /256
            s = (ch >= 3) ? TCS_SRC_DIV256 : TCS_SRC_EXT_A;
         end
         3'h5: begin
            s = (ch >= 3) ? TCS_SRC_DIV1024 : TCS_SRC_EXT_B;
         end
         3'h6: begin
            if (ch == 1) begin
               s = TCS_SRC_DIV256;
            end else if (ch >= 3) begin
               s = TCS_SRC_EXT_A;
            end else begin
               s = TCS_SRC_EXT_C;
            end
         end
         3'h7: begin
            if (ch == 0) begin
               s = TCS_SRC_EXT_D;
            end else if (ch == 1) begin
               s = TCS_SRC_OVF2;
            end else if (ch == 2) begin
               s = TCS_SRC_DIV1024;
            end else begin
               s = TCS_SRC_EXT_B;
            end
         end
      endcase
      decode_src = s;
   endfunction

   // clear source decode; buffer use of c or d silences their events
   function automatic logic clear_hit(input logic [2:0] sel, input tcs_event_type ev,
                                      input logic buf_a, input logic buf_b, input logic sync_ok);
      unique case (sel)
         TCS_CLR_A: begin
            clear_hit = ev.match_a;
         end
         TCS_CLR_B: begin
            clear_hit = ev.match_b;
         end
         TCS_CLR_C: begin
            clear_hit = ev.match_c & ~buf_a;
         end
         TCS_CLR_D: begin
            clear_hit = ev.match_d & ~buf_b;
         end
         TCS_CLR_SYNC, TCS_CLR_SYNC_HI: begin
            clear_hit = sync_ok;
         end
         default: begin
            clear_hit = 1'b0;
         end
      endcase
   endfunction

   // reserved top bit on channels 1 and 2: writes never reach the decode
   assign eff_sel = HAS_CD ? ctrl.clear_sel : {1'b0, ctrl.clear_sel[1:0]};

   // pins are synchronous to clk, so one sample is enough for edge detect
   assign pins = {ext_count_clock_d, ext_count_clock_c, ext_count_clock_b, ext_count_clock_a};
   assign pin_rise = pins & ~st_r.pin_prev;
   assign pin_fall = ~pins & st_r.pin_prev;

   // phase counting exists only on channels 1 and 2
   assign phase_on = HAS_PHASE & ctrl.phase_mode;
   assign src = decode_src(CHANNEL, ctrl.prescale_sel);

   // partner clears are followed only while our sync bit is set
   assign clr = clear_hit(eff_sel, gr_event, ctrl.buffer_a, ctrl.buffer_b,
                          timer_sync_enable & sync_clear_in);

   // count enable; /1 and channel 2 wraps ignore the edge select since
   // they have no edge to choose between
   always_comb begin
      step = 1'b0;
      if (phase_on) begin
         step = phase_step;
      end else begin
         unique case (src)
            TCS_SRC_DIV1: begin
               step = 1'b1;
            end
            TCS_SRC_DIV4: begin
               step = edge_pick(ctrl.edge_sel, tap_rise[TCS_TAP_DIV4], tap_fall[TCS_TAP_DIV4]);
            end
            TCS_SRC_DIV16: begin
               step = edge_pick(ctrl.edge_sel, tap_rise[TCS_TAP_DIV16], tap_fall[TCS_TAP_DIV16]);
            end
            TCS_SRC_DIV64: begin
               step = edge_pick(ctrl.edge_sel, tap_rise[TCS_TAP_DIV64], tap_fall[TCS_TAP_DIV64]);
            end
            TCS_SRC_DIV256: begin
               step = edge_pick(ctrl.edge_sel, tap_rise[TCS_TAP_DIV256], tap_fall[TCS_TAP_DIV256]);
            end
            TCS_SRC_DIV1024: begin
               step = edge_pick(ctrl.edge_sel, tap_rise[TCS_TAP_DIV1024],
                                tap_fall[TCS_TAP_DIV1024]);
            end
            TCS_SRC_EXT_A: begin
               step = edge_pick(ctrl.edge_sel, pin_rise[0], pin_fall[0]);
            end
            TCS_SRC_EXT_B: begin
               step = edge_pick(ctrl.edge_sel, pin_rise[1], pin_fall[1]);
            end
            TCS_SRC_EXT_C: begin
               step = edge_pick(ctrl.edge_sel, pin_rise[2], pin_fall[2]);
            end
            TCS_SRC_EXT_D: begin
               step = edge_pick(ctrl.edge_sel, pin_rise[3], pin_fall[3]);
            end
            TCS_SRC_OVF2: begin
               step = channel2_counter_wrap;
            end
            default: begin
               step = 1'b0;
            end
         endcase
      end
   end

   // next state; a clear beats a count step in the same cycle
   always_comb begin
      st_nxt = st_r;
      st_nxt.pin_prev = pins;
      st_nxt.sel_rd = eff_sel;
      st_nxt.cleared = 1'b0;
      st_nxt.wrap = 1'b0;
      st_nxt.tick = 1'b0;
      if (clr) begin
         st_nxt.counter = '0;
         st_nxt.cleared = 1'b1;
      end else if (step) begin
         st_nxt.tick = 1'b1;
         if (phase_on && phase_down) begin
            // underflow only reachable through phase counting
            st_nxt.wrap = (st_r.counter == '0);
            st_nxt.counter = CNT_W'(st_r.counter - 1'b1);
         end else begin
            st_nxt.wrap = &st_r.counter;
            st_nxt.counter = CNT_W'(st_r.counter + 1'b1);
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.sel_rd <= TCS_SEL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state
   assign timer_counter_value = st_r.counter;
   assign clear_select_rd = st_r.sel_rd;
   assign counter_cleared = st_r.cleared;
   assign counter_wrap = st_r.wrap;
   assign count_tick = st_r.tick;

   // checks on the channel behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // a clear is seen as a zero counter and a cleared pulse one edge later
   sequence s_cleared;
      ##1 (timer_counter_value == '0) && counter_cleared;
   endsequence

   // the /4 enable stays low for the next three edges unless the setup moves;
   // the tap is watched rather than count_tick, which lags it by one edge
   sequence s_quiet3;
      ##1 (!step || phase_on || src != TCS_SRC_DIV4 || ctrl.edge_sel[TCS_EDGE_BOTH_BIT]) [*3];
   endsequence

   property p_no_clear_off;
      (eff_sel == TCS_CLR_OFF || eff_sel == TCS_CLR_OFF_HI) |=> !counter_cleared;
   endproperty
   a_no_clear_off: assert property (p_no_clear_off) else $error("counter cleared with clearing off");

   property p_clear_a;
      (eff_sel == TCS_CLR_A && gr_event.match_a) |-> s_cleared;
   endproperty
   a_clear_a: assert property (p_clear_a) else $error("register a event did not clear");

   property p_clear_b;
      (eff_sel == TCS_CLR_B && gr_event.match_b) |-> s_cleared;
   endproperty
   a_clear_b: assert property (p_clear_b) else $error("register b event did not clear");

   property p_sync_clear;
      (eff_sel[1:0] == TCS_CLR_SYNC_LOW && timer_sync_enable && sync_clear_in) |-> s_cleared;
   endproperty
   a_sync_clear: assert property (p_sync_clear) else $error("synchronous clear missed");

   property p_sync_gate;
      (eff_sel[1:0] == TCS_CLR_SYNC_LOW && !timer_sync_enable) |=> !counter_cleared;
   endproperty
   a_sync_gate: assert property (p_sync_gate) else $error("cleared while not synchronous");

   property p_buffer_block;
      ((eff_sel == TCS_CLR_C && ctrl.buffer_a) || (eff_sel == TCS_CLR_D && ctrl.buffer_b))
         |=> !counter_cleared;
   endproperty
   a_buffer_block: assert property (p_buffer_block) else $error("buffered register cleared");

   property p_reserved_bit;
      !HAS_CD |-> (clear_select_rd[2] == 1'b0);
   endproperty
   a_reserved_bit: assert property (p_reserved_bit) else $error("reserved clear bit read as one");

   property p_div1_every_edge;
      (!phase_on && src == TCS_SRC_DIV1 && !clr && ctrl.edge_sel != TCS_EDGE_RISE)
         |=> count_tick && timer_counter_value == CNT_W'($past(timer_counter_value) + 1'b1);
   endproperty
   a_div1_every_edge: assert property (p_div1_every_edge) else $error("divide by 1 did not count");

   property p_div4_rate;
      (!phase_on && src == TCS_SRC_DIV4 && !ctrl.edge_sel[TCS_EDGE_BOTH_BIT] && step && !clr)
         |-> s_quiet3;
   endproperty
   a_div4_rate: assert property (p_div4_rate) else $error("divide by 4 stepped too often");

   property p_ovf_source;
      (!phase_on && src == TCS_SRC_OVF2 && channel2_counter_wrap && !clr) |=> count_tick;
   endproperty
   a_ovf_source: assert property (p_ovf_source) else $error("channel 2 wrap not counted");

   property p_phase_owns;
      (phase_on && !phase_step) |=> !count_tick;
   endproperty
   a_phase_owns: assert property (p_phase_owns) else $error("prescaler counted in phase mode");

endmodule

//--- testbench/tb.sv
// self-checking bench for the clear source decode and count clock select of three channels
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
   $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb
   import tcs_pkg::*;
;
   logic clk; // 25 MHz clock
   logic reset_n; // async active low reset
   tcs_ctrl_type ctrl; // shared selection fields
   tcs_event_type ev; // shared general register events
   logic sync_en, sync_in, wrap2, step, down; // shared strobes and levels
   logic [3:0] pins; // external count clocks a..d, bit 0 is a
   logic [15:0] cnt0, cnt1; // counter values
   logic [2:0] rd0, rd1; // clear select readback
   logic clr0, clr1, tick0, tick1, tick3, wrap1; // cleared, step and wrap pulses
   int failures = 0; // mismatch count
   int total_checks = 0; // comparison count
   int n0 = 0, n1 = 0, n3 = 0; // running tick counts per channel

   // channel 0 holds the full clear code set
   tcs_channel #(.CHANNEL(0)) DUT (.clk(clk), .reset_n(reset_n), .ctrl(ctrl), .gr_event(ev),
      .timer_sync_enable(sync_en), .sync_clear_in(sync_in), .ext_count_clock_a(pins[0]),
      .ext_count_clock_b(pins[1]), .ext_count_clock_c(pins[2]), .ext_count_clock_d(pins[3]),
      .channel2_counter_wrap(wrap2), .phase_step(step), .phase_down(down), .timer_counter_value(cnt0),
      .clear_select_rd(rd0), .counter_cleared(clr0), .counter_wrap(), .count_tick(tick0));
   // channel 1 sees the same inputs, so reserved bits and its own taps show up side by side
   tcs_channel #(.CHANNEL(1)) DUT1 (.clk(clk), .reset_n(reset_n), .ctrl(ctrl), .gr_event(ev),
      .timer_sync_enable(sync_en), .sync_clear_in(sync_in), .ext_count_clock_a(pins[0]),
      .ext_count_clock_b(pins[1]), .ext_count_clock_c(pins[2]), .ext_count_clock_d(pins[3]),
      .channel2_counter_wrap(wrap2), .phase_step(step), .phase_down(down), .timer_counter_value(cnt1),
      .clear_select_rd(rd1), .counter_cleared(clr1), .counter_wrap(wrap1), .count_tick(tick1));
   // channel 3 has the /256 tap where channel 0 has a pin
   tcs_channel #(.CHANNEL(3)) DUT3 (.clk(clk), .reset_n(reset_n), .ctrl(ctrl), .gr_event(ev),
      .timer_sync_enable(sync_en), .sync_clear_in(sync_in), .ext_count_clock_a(pins[0]),
      .ext_count_clock_b(pins[1]), .ext_count_clock_c(pins[2]), .ext_count_clock_d(pins[3]),
      .channel2_counter_wrap(wrap2), .phase_step(step), .phase_down(down), .timer_counter_value(),
      .clear_select_rd(), .counter_cleared(), .counter_wrap(), .count_tick(tick3));

   // clock generator
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   // step pulses are tallied here so windows can be measured by difference
   always @(posedge clk) begin
      if (tick0 === 1'h1) n0 <= n0 + 1;
      if (tick1 === 1'h1) n1 <= n1 + 1;
      if (tick3 === 1'h1) n3 <= n3 + 1;
   end

   // prints the counts and the verdict, then stops
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // new selection fields, then a few edges so the registered readback settles
   task automatic set_ctrl(input logic [2:0] c, input logic [1:0] e, input logic [2:0] p,
      input logic ba, input logic bb, input logic ph);
      @(posedge clk);
      ctrl <= '{c, e, p, ba, bb, ph};
      repeat (3) @(posedge clk);
      // step past the edge so the tallies already hold its increment
      #1;
   endtask

   // one-cycle strobes; on return the result of the sampling edge is settled
   task automatic pulse(input tcs_event_type e, input logic s, input logic w, input logic st);
      @(posedge clk);
      ev <= e;
      sync_in <= s;
      wrap2 <= w;
      step <= st;
      @(posedge clk);
      ev <= '0;
      sync_in <= 1'h0;
      wrap2 <= 1'h0;
      step <= 1'h0;
      #1;
   endtask

   // counts steps of both channels over a window of edges
   task automatic run_win(input int cyc, output int d0, output int d1);
      int a0, a1;
      a0 = n0;
      a1 = n1;
      repeat (cyc) @(posedge clk);
      #1;
      d0 = n0 - a0;
      d1 = n1 - a1;
   endtask

   // every clear code against every register event, counter running on the undivided clock
   task automatic t_clear();
      logic e0, e1;
      for (int c = 0; c < 8; c++) begin
         set_ctrl(c[2:0], 2'h0, 3'h0, 1'h0, 1'h0, 1'h0);
         `CHK("rd0", c[2:0], rd0)
         `CHK("rd1", {1'h0, c[1:0]}, rd1)
         for (int e = 0; e < 4; e++) begin
            e0 = (c == 1 && e == 0) || (c == 2 && e == 1) || (c == 5 && e == 2) || (c == 6 && e == 3);
            e1 = (c[1:0] == 2'h1 && e == 0) || (c[1:0] == 2'h2 && e == 1);
            pulse(tcs_event_type'(4'h8 >> e), 1'h0, 1'h0, 1'h0);
            `CHK("clr0", e0, clr0)
            `CHK("clr1", e1, clr1)
            if (e0) `CHK("cnt0", 16'h0000, cnt0)
         end
      end
      $display("clear decode test done");
   endtask

   // synchronous clearing follows the sync bit; buffered c and d never clear
   task automatic t_sync_buf();
      for (int k = 0; k < 4; k++) begin
         set_ctrl(k[1] ? 3'h7 : 3'h3, 2'h0, 3'h0, 1'h0, 1'h0, 1'h0);
         sync_en <= k[0];
         pulse('0, 1'h1, 1'h0, 1'h0);
         `CHK("sync clr0", k[0], clr0)
         `CHK("sync clr1", k[0], clr1)
      end
      sync_en <= 1'h0;
      for (int b = 0; b < 2; b++) begin
         set_ctrl(3'h5 + b[2:0], 2'h0, 3'h0, b == 0, b == 1, 1'h0);
         pulse(tcs_event_type'(4'h2 >> b), 1'h0, 1'h0, 1'h0);
         `CHK("buffered clr0", 1'h0, clr0)
      end
      $display("sync and buffer test done");
   endtask

   // internal taps measured over 256 edges, with edge selection on the /4 and /1 settings
   task automatic t_prescale();
      int d0, d1, a3;
      for (int c = 0; c < 5; c++) begin
         set_ctrl(3'h0, 2'h0, c[2:0], 1'h0, 1'h0, 1'h0);
         a3 = n3;
         run_win(256, d0, d1);
         `CHK("tap ch0", c == 4 ? 0 : 256 >> (2 * c), d0)
         `CHK("tap ch1", c == 4 ? 0 : 256 >> (2 * c), d1)
         `CHK("tap ch3", c == 4 ? 1 : 256 >> (2 * c), n3 - a3)
      end
      set_ctrl(3'h0, 2'h0, 3'h6, 1'h0, 1'h0, 1'h0);
      run_win(256, d0, d1);
      `CHK("idle pin c ch0", 0, d0)
      `CHK("div256 ch1", 1, d1)
      set_ctrl(3'h0, 2'h2, 3'h1, 1'h0, 1'h0, 1'h0);
      run_win(256, d0, d1);
      `CHK("div4 both", 128, d0)
      set_ctrl(3'h0, 2'h1, 3'h1, 1'h0, 1'h0, 1'h0);
      run_win(256, d0, d1);
      `CHK("div4 fall", 64, d0)
      set_ctrl(3'h0, 2'h2, 3'h0, 1'h0, 1'h0, 1'h0);
      run_win(256, d0, d1);
      `CHK("div1 both ignored", 256, d0)
      $display("prescale test done");
   endtask

   // each external pin pulsed high eight times, counted on rising and on both edges
   task automatic t_ext();
      int a0, a1;
      for (int m = 0; m < 8; m++) begin
         set_ctrl(3'h0, m[2] ? 2'h2 : 2'h0, 3'h4 + {1'h0, m[1:0]}, 1'h0, 1'h0, 1'h0);
         a0 = n0;
         a1 = n1;
         for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            pins[m[1:0]] <= 1'h1;
            repeat (4) @(posedge clk);
            pins[m[1:0]] <= 1'h0;
            repeat (3) @(posedge clk);
         end
         repeat (3) @(posedge clk);
         #1;
         `CHK("ext ch0", m[2] ? 16 : 8, n0 - a0)
         if (m[1] == 1'h0) `CHK("ext ch1", m[2] ? 16 : 8, n1 - a1)
      end
      $display("external clock test done");
   endtask

   // channel 2 wraps drive channel 1; phase mode stops the prescaler on channel 1 only
   task automatic t_wrap_phase();
      int d0, d1, a1;
      set_ctrl(3'h0, 2'h0, 3'h7, 1'h0, 1'h0, 1'h0);
      a1 = n1;
      repeat (5) pulse('0, 1'h0, 1'h1, 1'h0);
      run_win(2, d0, d1);
      `CHK("wrap ch1", 5, n1 - a1)
      set_ctrl(3'h0, 2'h0, 3'h0, 1'h0, 1'h0, 1'h1);
      run_win(64, d0, d1);
      `CHK("phase ch0", 64, d0)
      `CHK("phase ch1", 0, d1)
      a1 = n1;
      repeat (3) pulse('0, 1'h0, 1'h0, 1'h1);
      run_win(2, d0, d1);
      `CHK("phase steps ch1", 3, n1 - a1)
      // clear channel 1, then one downward phase step must underflow it
      set_ctrl(3'h1, 2'h0, 3'h0, 1'h0, 1'h0, 1'h1);
      pulse(tcs_event_type'(4'h8), 1'h0, 1'h0, 1'h0);
      `CHK("phase clear ch1", 16'h0000, cnt1)
      @(posedge clk);
      down <= 1'h1;
      pulse('0, 1'h0, 1'h0, 1'h1);
      `CHK("phase down ch1", 16'hffff, cnt1)
      `CHK("phase wrap ch1", 1'h1, wrap1)
      $display("wrap and phase test done");
   endtask

   // main sequence
   initial begin
      reset_n = 1'h0;
      ctrl = '0;
      ev = '0;
      sync_en = 1'h0;
      sync_in = 1'h0;
      wrap2 = 1'h0;
      step = 1'h0;
      down = 1'h0;
      pins = 4'h0;
      repeat (16) @(posedge clk);
      reset_n <= 1'h1;
      #1;
      `CHK("reset cnt0", 16'h0000, cnt0)
      `CHK("reset rd1", 3'h0, rd1)
      t_clear();
      t_sync_buf();
      t_prescale();
      t_ext();
      t_wrap_phase();
      tally_and_finish();
   end

   // watchdog: the whole sequence needs well under 8000 edges
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("watchdog expired");
      tally_and_finish();
   end
endmodule
